// ---- design/timer_prescaler.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic srcTick,
  input wire logic [2:0] prescaleSelect,
  output logic countTick
);
  logic [6:0] divider_reg;
  logic [6:0] mask;

  always_comb begin
    mask = 7'((8'h01 << prescaleSelect) - 8'h01);
  end

  // Only reset clears the divider; prescale changes and counter clears leave it running on
  always_ff @(posedge clk) begin
    if (rst) begin
      divider_reg <= timer_pwm_pkg::DIVIDER_RESET;
    end else if (srcTick) begin
      divider_reg <= divider_reg + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      countTick <= 1'b0;
    end else begin
      countTick <= srcTick && ((divider_reg & mask) == mask);
    end
  end
endmodule
`default_nettype wire

// ---- design/timer_pwm_counter_restart.sv ----
// What this block does
// - In edge-aligned mode a compare value going from zero to non-zero gives one extra 0% period first.
// - Writing the clock-source select to off stops all count clocks to the counter.
// - Writing a non-off clock source resumes counting on the selected prescaled clock.
// - Any write to the counter register clears the whole counter to zero regardless of data.
// - Prescale changes and counter clears leave the prescaler divider running from its old value.
// - In center-aligned mode the direction flag turns from up to down on the edge the count lands on the modulo.
// - Clearing the counter leaves the direction flag alone, so a stale down flag counts through 0xffff.
// - In center-aligned mode a negative compare value gives 0% duty.
`timescale 1ns/1ns
`default_nettype none
module timer_pwm_counter_restart (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClk,
  output logic pwmOut
);
  // ==========================================================
  // Registers and wires
  logic [2:0] prescaleSelect_reg;
  logic [1:0] clockSourceSelect_reg;
  logic centerMode_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] modulo_reg;
  logic [15:0] compareBuf_reg;
  logic [15:0] compareActive_reg;
  logic lateLoad_reg;
  logic countDown_reg;
  logic countDown_next;
  logic [3:0] fixedDiv_reg;
  logic fixedTick;
  logic extClkPrev_reg;
  logic srcTick;
  logic countTick;
  logic periodEnd;
  logic wrDone;
  logic addrOk;
  logic [31:0] readValue;
  localparam int PRESCALE_HI = timer_pwm_pkg::PRESCALE_LSB + timer_pwm_pkg::PRESCALE_W - 1;
  localparam int CS_HI = timer_pwm_pkg::CLKSRC_LSB + timer_pwm_pkg::CLKSRC_W - 1;

  // ==========================================================
  // APB slave: one wait state, write lands on the completing edge
  assign wrDone = psel && penable && pready && pwrite;

  always_comb begin
    addrOk = 1'b1;
    readValue = 32'h0000_0000;
    case (paddr)
      timer_pwm_pkg::ADDR_CTRL: begin
        readValue[PRESCALE_HI:timer_pwm_pkg::PRESCALE_LSB] = prescaleSelect_reg;
        readValue[CS_HI:timer_pwm_pkg::CLKSRC_LSB] = clockSourceSelect_reg;
        readValue[timer_pwm_pkg::CENTER_BIT] = centerMode_reg;
      end
      timer_pwm_pkg::ADDR_COUNT: readValue[15:0] = count_reg;
      timer_pwm_pkg::ADDR_MODULO: readValue[15:0] = modulo_reg;
      timer_pwm_pkg::ADDR_COMPARE: readValue[15:0] = compareBuf_reg;
      timer_pwm_pkg::ADDR_STATUS: readValue[timer_pwm_pkg::DIR_BIT] = countDown_reg;
      default: addrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !addrOk;
      prdata <= pwrite ? 32'h0000_0000 : readValue;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Control, modulo and compare buffer
  always_ff @(posedge clk) begin
    if (rst) begin
      prescaleSelect_reg <= timer_pwm_pkg::PRESCALE_RESET;
      clockSourceSelect_reg <= timer_pwm_pkg::CLK_OFF;
      centerMode_reg <= 1'b0;
    end else if (wrDone && !pslverr && paddr == timer_pwm_pkg::ADDR_CTRL && pstrb[0]) begin
      prescaleSelect_reg <= pwdata[PRESCALE_HI:timer_pwm_pkg::PRESCALE_LSB];
      clockSourceSelect_reg <= pwdata[CS_HI:timer_pwm_pkg::CLKSRC_LSB];
      centerMode_reg <= pwdata[timer_pwm_pkg::CENTER_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modulo_reg <= timer_pwm_pkg::MODULO_RESET;
    end else if (wrDone && paddr == timer_pwm_pkg::ADDR_MODULO) begin
      if (pstrb[0]) begin
        modulo_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        modulo_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compareBuf_reg <= timer_pwm_pkg::COMPARE_RESET;
    end else if (wrDone && paddr == timer_pwm_pkg::ADDR_COMPARE) begin
      if (pstrb[0]) begin
        compareBuf_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        compareBuf_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  // ==========================================================
  // Count-clock sources; nothing reaches the prescaler while off
  always_ff @(posedge clk) begin
    if (rst) begin
      fixedDiv_reg <= 4'h0;
    end else if (fixedDiv_reg == timer_pwm_pkg::FIXED_DIV_LAST) begin
      fixedDiv_reg <= 4'h0;
    end else begin
      fixedDiv_reg <= fixedDiv_reg + 4'h1;
    end
  end

  assign fixedTick = (fixedDiv_reg == timer_pwm_pkg::FIXED_DIV_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      extClkPrev_reg <= 1'b0;
    end else begin
      extClkPrev_reg <= extClk;
    end
  end

  always_comb begin
    case (clockSourceSelect_reg)
      timer_pwm_pkg::CLK_OFF: srcTick = 1'b0;
      timer_pwm_pkg::CLK_BUS: srcTick = 1'b1;
      timer_pwm_pkg::CLK_FIXED: srcTick = fixedTick;
      timer_pwm_pkg::CLK_EXT: srcTick = extClk && !extClkPrev_reg;
      default: srcTick = 1'b0;
    endcase
  end

  timer_prescaler prescaler (
    .clk(clk),
    .rst(rst),
    .srcTick(srcTick),
    .prescaleSelect(prescaleSelect_reg),
    .countTick(countTick)
  );

  // ==========================================================
  // Counter and direction
  // Direction flag follows the value the count lands on, so a stopped
  // count at the modulo already carries the down flag into a restart.
  always_comb begin
    count_next = count_reg;
    countDown_next = countDown_reg;
    if (!centerMode_reg) begin
      count_next = (count_reg == modulo_reg) ? 16'h0000 : count_reg + 16'h0001;
      countDown_next = 1'b0;
    end else begin
      count_next = countDown_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
      if (!countDown_reg && count_next == modulo_reg) begin
        countDown_next = 1'b1;
      end else if (countDown_reg && count_next == 16'h0000) begin
        countDown_next = 1'b0;
      end
    end
  end

  assign periodEnd = countTick && (count_next == 16'h0000);

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= timer_pwm_pkg::COUNT_RESET;
    end else if (wrDone && paddr == timer_pwm_pkg::ADDR_COUNT) begin
      count_reg <= timer_pwm_pkg::COUNT_RESET;
    end else if (countTick) begin
      count_reg <= count_next;
    end
  end

  // Counter clear leaves this flag untouched on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      countDown_reg <= 1'b0;
    end else if (countTick) begin
      countDown_reg <= countDown_next;
    end
  end

  // ==========================================================
  // Compare load at period start and PWM output
  always_ff @(posedge clk) begin
    if (rst) begin
      compareActive_reg <= timer_pwm_pkg::COMPARE_RESET;
      lateLoad_reg <= 1'b0;
    end else if (periodEnd) begin
      if (!centerMode_reg && compareActive_reg == 16'h0000 && compareBuf_reg != 16'h0000 && !lateLoad_reg) begin
        lateLoad_reg <= 1'b1;
      end else begin
        compareActive_reg <= compareBuf_reg;
        lateLoad_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwmOut <= 1'b0;
    end else if (centerMode_reg) begin
      pwmOut <= !compareActive_reg[15] && (count_reg < compareActive_reg);
    end else begin
      pwmOut <= count_reg < compareActive_reg;
    end
  end
endmodule
`default_nettype wire

// ---- design/timer_pwm_pkg.sv ----
package timer_pwm_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_MODULO = 12'h008;
  localparam logic [11:0] ADDR_COMPARE = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  // ==========================================================
  // Control and status register fields
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 3;
  localparam int CLKSRC_LSB = 3;
  localparam int CLKSRC_W = 2;
  localparam int CENTER_BIT = 5;
  localparam int DIR_BIT = 0;
  // ==========================================================
  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [6:0] DIVIDER_RESET = 7'h00;
  // ==========================================================
  // Clock-source select encodings
  typedef enum logic [1:0] {
    CLK_OFF = 2'h0,
    CLK_BUS = 2'h1,
    CLK_FIXED = 2'h2,
    CLK_EXT = 2'h3
  } clock_source_t;
  // Fixed-rate source is the bus clock divided by this count
  localparam int FIXED_DIV = 2;
  localparam logic [3:0] FIXED_DIV_LAST = 4'(FIXED_DIV - 1);
endpackage

// ---- tb/timer_pwm_counter_restart_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer_pwm_counter_restart_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extClk,
  input wire logic pwmOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // APB answer timing
  sequence s_first_access;
    psel && penable && !$past(penable);
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_one_wait: assert property (s_first_access |-> !pready ##1 s_answer)
    else $error("pready not exactly one wait state after access start");
  a_ready_has_cause: assert property (pready |-> $past(psel && penable) && psel && penable)
    else $error("pready without a pending access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped address refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_refused_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_reset_quiet: assert property ($fell(rst) |-> !pready && !pwmOut && !pslverr)
    else $error("outputs active right after reset");
endmodule
bind timer_pwm_counter_restart timer_pwm_counter_restart_asserts u_asserts (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .extClk(extClk), .pwmOut(pwmOut));
`default_nettype wire

// ---- tb/timer_pwm_counter_restart_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module timer_pwm_counter_restart_bench;
  logic clk, rst, psel, penable, pwrite, extClk, pready, pslverr, pwmOut, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int miscompares, total_checks, cyc, seen;
  timer_pwm_counter_restart u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extClk(extClk), .pwmOut(pwmOut));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // Shared tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge; answer taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset_values;
    apb(1'b0, timer_pwm_pkg::ADDR_MODULO, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task automatic t_ext_count;
    logic [31:0] first;
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h18);
    repeat (5) begin
      @(posedge clk) extClk <= 1'b1;
      @(posedge clk) extClk <= 1'b0;
    end
    repeat (3) @(posedge clk);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd, 32'h5);
    repeat (20) @(posedge clk);
    apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, timer_pwm_pkg::ADDR_COUNT, 32'habcd, 4'h2);
    apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd, 32'h0);
    // Divider sits at 5 after five source edges, so divide-by-2 ticks on the first edge
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h01);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h19);
    @(posedge clk) extClk <= 1'b1;
    @(posedge clk) extClk <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd, 32'h1);
    // Back-to-back reads sample four cycles apart: two fixed-rate ticks
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h10);
    apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    first = rd;
    apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd - first, 32'h2);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, timer_pwm_pkg::ADDR_COUNT, 32'h0);
  endtask
  // Slow prescale leaves time to stop the count while it sits at the modulo
  task automatic t_restart_dir;
    apb(1'b1, timer_pwm_pkg::ADDR_MODULO, 32'h3);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h2f);
    rd = 32'h0;
    for (int i = 0; i < 300 && rd !== 32'h3; i++) apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h21);
    apb(1'b1, timer_pwm_pkg::ADDR_COUNT, 32'h5a5a);
    apb(1'b0, timer_pwm_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h2f);
    rd = 32'h0;
    for (int i = 0; i < 300 && rd === 32'h0; i++) apb(1'b0, timer_pwm_pkg::ADDR_COUNT, 32'h0);
    chk(rd, 32'hffff);
  endtask
  task automatic t_negative_compare;
    do_reset();
    apb(1'b1, timer_pwm_pkg::ADDR_MODULO, 32'h4);
    apb(1'b1, timer_pwm_pkg::ADDR_COMPARE, 32'h8000);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h28);
    seen = 0;
    repeat (100) @(negedge clk) if (pwmOut !== 1'b0) seen++;
    chk(seen, 32'h0);
    apb(1'b1, timer_pwm_pkg::ADDR_COMPARE, 32'h2);
    seen = 0;
    repeat (100) @(negedge clk) if (pwmOut === 1'b1) seen++;
    chk(seen != 0, 32'h1);
  endtask
  // Period of four counts; a direct load would show high within six edges of the write
  task automatic t_late_duty;
    do_reset();
    apb(1'b1, timer_pwm_pkg::ADDR_MODULO, 32'h3);
    apb(1'b1, timer_pwm_pkg::ADDR_CTRL, 32'h08);
    repeat (12) @(posedge clk);
    apb(1'b1, timer_pwm_pkg::ADDR_COMPARE, 32'h2);
    seen = 0;
    repeat (6) @(negedge clk) if (pwmOut !== 1'b0) seen++;
    chk(seen, 32'h0);
    repeat (8) @(posedge clk);
    seen = 0;
    repeat (16) @(negedge clk) if (pwmOut === 1'b1) seen++;
    chk(seen, 32'h8);
  endtask
  // ==========================================================
  // Timeout and main sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {rst, psel, penable, pwrite, extClk} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    do_reset();
    t_reset_values();
    t_ext_count();
    t_restart_dir();
    t_negative_compare();
    t_late_duty();
    final_report();
  end
endmodule
`default_nettype wire
